/* File: verilog/sref_pkg.sv */
// package: register map, field layout, reset values and delay figures
package sref_pkg;
  // output, channel and register counts
  localparam int NREF = 7;
  localparam int NCLK = 8;
  localparam int NCH = 5;
  localparam int NREG = 9;
  // register byte offsets
  localparam logic [7:0] OFS_ROLE = 8'h00;
  localparam logic [7:0] OFS_REF_CTRL = 8'h04;
  localparam logic [7:0] OFS_REF_SWING = 8'h08;
  localparam logic [7:0] OFS_CLK_CTRL = 8'h0C;
  localparam logic [7:0] OFS_CLK_SWING = 8'h10;
  localparam logic [7:0] OFS_CLK_DLY_AD = 8'h14;
  localparam logic [7:0] OFS_DLY_E_GLB = 8'h18;
  localparam logic [7:0] OFS_REF_COARSE = 8'h1C;
  localparam logic [7:0] OFS_REF_FINE = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  // field positions in OFS_ROLE
  localparam int F_FUNC_SEL = 0;
  localparam int F_BIAS_TYPE = 8;
  localparam int F_VCXO_ON = 9;
  localparam int F_VCXO_STYLE = 10;
  localparam int F_VCXO_SWING = 12;
  // field positions in OFS_REF_CTRL
  localparam int F_REF_EN = 0;
  localparam int F_REF_BIAS = 8;
  localparam int F_REF_STYLE = 16;
  localparam int F_REF_PD = 24;
  // field positions in OFS_CLK_CTRL
  localparam int F_CLK_EN = 0;
  localparam int F_CLK_PD = 8;
  localparam int F_CLK_STYLE = 16;
  localparam int F_CHAN_PD = 24;
  // field positions in OFS_DLY_E_GLB
  localparam int F_GLB_DLY = 8;
  // writable bits per register index
  localparam logic [31:0] WMASK [NREG] = '{32'h0000_377F, 32'h7F7F_7F7F,
    32'h0000_3FFF, 32'h1FFF_FFFF, 32'h0000_FFFF, 32'hFFFF_FFFF,
    32'h0000_FFFF, 32'h001F_FFFF, 32'h001F_FFFF};
  // reset values: swings at 500 mV code, everything else clear
  localparam logic [31:0] RST_VAL [NREG] = '{32'h0000_1000, 32'h0000_0000,
    32'h0000_1555, 32'h0000_0000, 32'h0000_5555, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  // delay step sizes in ps
  localparam int VCO_PERIOD_PS = 254;
  localparam int COARSE_STEP_PS = 127;
  localparam int GLOBAL_STEP_PS = 509;
  localparam logic [7:0] FINE_PS [8] = '{8'h00, 8'h19, 8'h32, 8'h4B,
    8'h55, 8'h6E, 8'h87, 8'hA0};
  // output to channel maps
  localparam int REF_CH [NREF] = '{0, 0, 0, 1, 1, 2, 3};
  localparam int CLK_CH [NCLK] = '{0, 0, 1, 1, 2, 3, 4, 4};
  // types
  typedef enum logic [1:0] {EV_IDLE, EV_ACTIVE, EV_DONE} ev_state_t;
  typedef enum logic [2:0] {LINE_OFF, LINE_LOW, LINE_XPOINT, LINE_MID,
    LINE_ACTIVE} line_state_t;
  typedef logic [NREF-1:0] ref_vec_t;
  typedef logic [NCLK-1:0] clk_vec_t;
endpackage

/* File: verilog/out_cfg_if.sv */
// interface: settings of one output, from the register file to its controller
`timescale 1ns/1ps
`default_nettype none
interface out_cfg_if;
  logic power_down; // output (or channel) powered down
  logic enable; // output enable
  logic idle_bias; // midpoint bias while idle
  logic sysref_role; // 1 = sysref role
  logic [1:0] swing; // swing select
  logic style; // 0 lvds, 1 lvpecl
  modport src (output power_down, enable, idle_bias, sysref_role, swing, style);
  modport sink (input power_down, enable, idle_bias, sysref_role, swing, style);
endinterface
`default_nettype wire

/* File: verilog/sysref_line_ctrl.sv */
// module: line state of one reference output (sysref or clock role)
`timescale 1ns/1ps
`default_nettype none
module sysref_line_ctrl
  import sref_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // settings
  out_cfg_if.sink cfg,
  input wire logic bias_type,
  // activity sources
  input wire logic event_on,
  input wire logic pulse,
  input wire logic chan_clk,
  // line
  output logic sysref_out,
  output logic sysref_out_complement,
  output logic line_bias,
  output logic power_on,
  output logic [1:0] swing_out,
  output sref_pkg::line_state_t state
);
  // next line state: power-down first, then role, event, bias
  wire line_state_t st_nxt = cfg.power_down ? LINE_OFF :
    !cfg.sysref_role ? (cfg.enable ? LINE_ACTIVE : LINE_LOW) :
    (event_on && cfg.enable) ? LINE_ACTIVE :
    cfg.idle_bias ? LINE_MID :
    !cfg.enable ? LINE_LOW :
    bias_type ? LINE_XPOINT : LINE_LOW;
  // toggle source: generator pulses in sysref role, channel clock otherwise
  wire src = cfg.sysref_role ? pulse : chan_clk;
  // registered line levels
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= LINE_OFF;
      sysref_out <= 1'b0;
      sysref_out_complement <= 1'b0;
      line_bias <= 1'b0;
      power_on <= 1'b0;
      swing_out <= 2'b00;
    end
    else
    begin
      state <= st_nxt;
      sysref_out <= (st_nxt == LINE_ACTIVE) & src;
      sysref_out_complement <= (st_nxt == LINE_LOW) | ((st_nxt == LINE_ACTIVE) & ~src);
      line_bias <= (st_nxt == LINE_MID) | (st_nxt == LINE_XPOINT);
      power_on <= (st_nxt != LINE_OFF);
      swing_out <= cfg.swing;
    end
  end
  a_pd_forces_off: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg.power_down |=> !power_on && !sysref_out && !sysref_out_complement && !line_bias)
    else $error("powered-down output still active");
  a_disabled_low: assert property (@(posedge hclk) disable iff (!hresetn)
    (!cfg.power_down && cfg.sysref_role && !cfg.enable && !cfg.idle_bias)
    |=> sysref_out_complement && !sysref_out && !line_bias)
    else $error("disabled sysref output not at logic low");
  a_idle_xpoint: assert property (@(posedge hclk) disable iff (!hresetn)
    (!cfg.power_down && cfg.sysref_role && cfg.enable && !cfg.idle_bias && !event_on
    && bias_type) |=> line_bias && !sysref_out && !sysref_out_complement)
    else $error("idle sysref output not at cross-point");
endmodule // sysref_line_ctrl
`default_nettype wire

/* File: verilog/clk_out_ctrl.sv */
// module: power, enable and swing of one clock output
`timescale 1ns/1ps
`default_nettype none
module clk_out_ctrl
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // settings
  out_cfg_if.sink cfg,
  input wire logic chan_pd,
  input wire logic src,
  // output
  output logic clock_out,
  output logic power_on,
  output logic [1:0] swing_out
);
  // off by its own bit or by its channel
  wire off = cfg.power_down | chan_pd;
  // registered output levels
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clock_out <= 1'b0;
      power_on <= 1'b0;
      swing_out <= 2'b00;
    end
    else
    begin
      clock_out <= ~off & cfg.enable & src;
      power_on <= ~off;
      swing_out <= cfg.swing;
    end
  end
  a_clk_chan_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (chan_pd || cfg.power_down) |=> !power_on && !clock_out)
    else $error("clock output on while powered down");
endmodule // clk_out_ctrl
`default_nettype wire

/* File: verilog/sysref_output_ctrl.sv */
// module: register file, event state machine and delay settings of the outputs
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - sysref settings apply only to sysref-role outputs
// - power-down bit turns clock and clock-role outputs off unconditionally; sysref role follows channel power-down
// - per-output enable; disabled sysref output sits low unless idle bias is set
// - idle bias holds idle outputs at midpoint
// - state machine turns outputs on during event
// - power-down per channel and per clock output
// - independent swing select per output
// - bias type 0: static low around toggling
// - bias type 1: cross-point level around toggling
// - oscillator output on only when power-on set
// - clock and sysref delays set independently
// - clock delay 256 steps of one vco period
// - sysref coarse delay 8 vco-based steps
// - sysref fine delay eight-entry table
// - global sysref delay 256 double steps
module sysref_output_ctrl
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // asynchronous activity pins
  input wire logic sysref_event,
  input wire logic sysref_pulse,
  input wire logic [4:0] chan_clk,
  input wire logic vcxo_clk,
  // reference outputs
  output sref_pkg::ref_vec_t sysref_out,
  output sref_pkg::ref_vec_t sysref_out_complement,
  output sref_pkg::ref_vec_t ref_line_bias,
  output sref_pkg::ref_vec_t ref_power_on,
  output logic [6:0][1:0] ref_swing,
  output logic [6:0][17:0] ref_delay_ps,
  // clock outputs
  output sref_pkg::clk_vec_t clock_out,
  output sref_pkg::clk_vec_t clock_power_on,
  output logic [7:0][1:0] clock_swing,
  output logic [4:0][15:0] clock_delay_ps,
  // oscillator-loop output
  output logic vcxo_clock_out,
  output logic vcxo_out_power_on,
  output logic [1:0] vcxo_swing,
  output logic vcxo_style,
  // event state
  output logic sysref_event_active
);
  import sref_pkg::*;

  logic [31:0] regs_r [NREG]; // configuration words
  logic [7:0] sync1_r; // first synchroniser stage
  logic [7:0] sync2_r; // second synchroniser stage
  logic ev_prev_r; // event level one cycle back
  ev_state_t ev_r; // event state
  ev_state_t ev_nxt;
  logic wr_pend_r; // write data phase pending
  logic [3:0] wr_idx_r; // index of pending write

  // bus address phase decode
  wire addr_phase = hsel & hready & htrans[1];
  wire [3:0] a_idx = haddr[5:2];
  wire a_mapped = (haddr[31:6] == 26'h0) && (a_idx <= OFS_STATUS[5:2]);
  wire a_write = addr_phase & hwrite & a_mapped & (a_idx != OFS_STATUS[5:2]);
  wire a_read = addr_phase & ~hwrite;

  // settings fields
  wire [31:0] r_role = regs_r[OFS_ROLE[5:2]];
  wire [31:0] r_ref = regs_r[OFS_REF_CTRL[5:2]];
  wire [31:0] r_clk = regs_r[OFS_CLK_CTRL[5:2]];
  wire [NREF-1:0] func_sel = r_role[F_FUNC_SEL +: NREF];
  wire bias_type = r_role[F_BIAS_TYPE];
  wire [NCH-1:0] chan_pd = r_clk[F_CHAN_PD +: NCH];
  wire [39:0] clk_dly = {regs_r[OFS_DLY_E_GLB[5:2]][7:0], regs_r[OFS_CLK_DLY_AD[5:2]]};
  wire [7:0] glb_dly = regs_r[OFS_DLY_E_GLB[5:2]][F_GLB_DLY +: 8];

  // synchronised pin levels
  wire ev_s = sync2_r[0];
  wire pulse_s = sync2_r[1];
  wire [4:0] chan_clk_s = sync2_r[6:2];
  wire vcxo_s = sync2_r[7];

  // event state machine: start on rising level, done on falling
  assign ev_nxt = (ev_r == EV_IDLE && ev_s && !ev_prev_r) ? EV_ACTIVE :
    (ev_r == EV_ACTIVE && !ev_s) ? EV_DONE :
    (ev_r == EV_DONE) ? EV_IDLE : ev_r;
  wire event_on = (ev_r == EV_ACTIVE);

  // status word
  wire [31:0] status = {8'h00, clock_power_on, 1'b0, ref_power_on, 6'h00,
    ev_r == EV_DONE, event_on};
  // read word, forwarding a write still in its data phase
  wire [31:0] rd_word = (a_idx == OFS_STATUS[5:2]) ? status :
    (wr_pend_r && wr_idx_r == a_idx) ? (hwdata & WMASK[a_idx]) :
    a_mapped ? regs_r[a_idx] : 32'h0000_0000;

  // zero-wait, always-okay slave
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // pin synchronisers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
    end
    else
    begin
      sync1_r <= {vcxo_clk, chan_clk, sysref_pulse, sysref_event};
      sync2_r <= sync1_r;
    end
  end

  // event state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ev_r <= EV_IDLE;
      ev_prev_r <= 1'b0;
      sysref_event_active <= 1'b0;
    end
    else
    begin
      ev_r <= ev_nxt;
      ev_prev_r <= ev_s;
      sysref_event_active <= (ev_nxt == EV_ACTIVE);
    end
  end

  // bus phase tracking and read data
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 4'h0;
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_r <= a_write;
      wr_idx_r <= a_idx;
      if (a_read)
      begin
        hrdata <= rd_word;
      end
    end
  end

  // configuration words: written at the end of the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      regs_r <= RST_VAL;
    end
    else if (wr_pend_r)
    begin
      regs_r[wr_idx_r] <= hwdata & WMASK[wr_idx_r];
    end
  end

  // oscillator-loop output
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vcxo_clock_out <= 1'b0;
      vcxo_out_power_on <= 1'b0;
      vcxo_swing <= 2'b00;
      vcxo_style <= 1'b0;
    end
    else
    begin
      vcxo_out_power_on <= r_role[F_VCXO_ON];
      vcxo_clock_out <= r_role[F_VCXO_ON] & vcxo_s;
      vcxo_swing <= r_role[F_VCXO_SWING +: 2];
      vcxo_style <= r_role[F_VCXO_STYLE];
    end
  end

  // clock delay per channel, one vco period a step
  for (genvar c = 0; c < NCH; c++)
  begin : g_chan
    wire [15:0] cd_nxt = 16'(clk_dly[8*c +: 8] * VCO_PERIOD_PS);
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        clock_delay_ps[c] <= 16'h0000;
      end
      else
      begin
        clock_delay_ps[c] <= cd_nxt;
      end
    end
  end

  // reference outputs
  for (genvar r = 0; r < NREF; r++)
  begin : g_ref
    out_cfg_if cfg ();
    // sysref role is powered per channel, clock role per output
    assign cfg.power_down = func_sel[r] ? chan_pd[REF_CH[r]] : r_ref[F_REF_PD + r];
    assign cfg.enable = r_ref[F_REF_EN + r];
    assign cfg.idle_bias = r_ref[F_REF_BIAS + r];
    assign cfg.sysref_role = func_sel[r];
    assign cfg.swing = regs_r[OFS_REF_SWING[5:2]][2*r +: 2];
    assign cfg.style = r_ref[F_REF_STYLE + r];
    wire [2:0] coarse = regs_r[OFS_REF_COARSE[5:2]][3*r +: 3];
    wire [2:0] fine = regs_r[OFS_REF_FINE[5:2]][3*r +: 3];
    // sysref path sums global, coarse and fine; clock role follows channel
    wire [17:0] rd_nxt = func_sel[r] ?
      18'(glb_dly * GLOBAL_STEP_PS + coarse * COARSE_STEP_PS + FINE_PS[fine]) :
      18'(clk_dly[8*REF_CH[r] +: 8] * VCO_PERIOD_PS);
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        ref_delay_ps[r] <= 18'h0_0000;
      end
      else
      begin
        ref_delay_ps[r] <= rd_nxt;
      end
    end
    sysref_line_ctrl u_line (
      .hclk(hclk),
      .hresetn(hresetn),
      .cfg(cfg),
      .bias_type(bias_type),
      .event_on(event_on),
      .pulse(pulse_s),
      .chan_clk(chan_clk_s[REF_CH[r]]),
      .sysref_out(sysref_out[r]),
      .sysref_out_complement(sysref_out_complement[r]),
      .line_bias(ref_line_bias[r]),
      .power_on(ref_power_on[r]),
      .swing_out(ref_swing[r]),
      .state()
    );
  end

  // clock outputs
  for (genvar k = 0; k < NCLK; k++)
  begin : g_clk
    out_cfg_if cfg ();
    assign cfg.power_down = r_clk[F_CLK_PD + k];
    assign cfg.enable = r_clk[F_CLK_EN + k];
    assign cfg.idle_bias = 1'b0;
    assign cfg.sysref_role = 1'b0;
    assign cfg.swing = regs_r[OFS_CLK_SWING[5:2]][2*k +: 2];
    assign cfg.style = r_clk[F_CLK_STYLE + k];
    clk_out_ctrl u_clk (
      .hclk(hclk),
      .hresetn(hresetn),
      .cfg(cfg),
      .chan_pd(chan_pd[CLK_CH[k]]),
      .src(chan_clk_s[CLK_CH[k]]),
      .clock_out(clock_out[k]),
      .power_on(clock_power_on[k]),
      .swing_out(clock_swing[k])
    );
  end

  a_event_start: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev_r == EV_IDLE && ev_s && !ev_prev_r) |=> event_on ##0 sysref_event_active)
    else $error("event did not start");
  a_event_end: assert property (@(posedge hclk) disable iff (!hresetn)
    (event_on && !ev_s) |=> (ev_r == EV_DONE) ##1 (ev_r == EV_IDLE))
    else $error("event did not complete");
  a_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
    a_write |=> ##1 (regs_r[$past(a_idx, 2)] == ($past(hwdata) & WMASK[$past(a_idx, 2)])))
    else $error("register write lost");
  a_vcxo_power: assert property (@(posedge hclk) disable iff (!hresetn)
    !r_role[F_VCXO_ON] |=> !vcxo_out_power_on && !vcxo_clock_out)
    else $error("oscillator output on while power-on clear");
  a_clk_delay: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> clock_delay_ps[4] == 16'($past(clk_dly[39:32]) * 254))
    else $error("clock delay step wrong");
  a_fine_table: assert property (@(posedge hclk) disable iff (!hresetn)
    (func_sel[0] && glb_dly == 8'h00 && regs_r[OFS_REF_COARSE[5:2]][2:0] == 3'h0
    && regs_r[OFS_REF_FINE[5:2]][2:0] == 3'h4) |=> ref_delay_ps[0] == 18'd85)
    else $error("fine delay code 4 not 85 ps");
  a_global_delay: assert property (@(posedge hclk) disable iff (!hresetn)
    (func_sel[6] && regs_r[OFS_REF_COARSE[5:2]][20:18] == 3'h1
    && regs_r[OFS_REF_FINE[5:2]][20:18] == 3'h0)
    |=> ref_delay_ps[6] == 18'($past(glb_dly) * 509 + 127))
    else $error("global plus coarse delay wrong");
endmodule // sysref_output_ctrl
`default_nettype wire

/* File: verif/conv_model.sv */
// partner model: converter input counting sysref edges and checking the swing code
`timescale 1ns/1ps
`default_nettype none
module conv_model
(
  // clock and clear
  input wire logic hclk,
  input wire logic clr,
  // lines arriving from the controller
  input wire logic [6:0] sysref_out,
  input wire logic [6:0][1:0] ref_swing,
  input wire logic active,
  // observed results
  output logic [7:0] edge_count,
  output logic swing_bad
);
  logic prev_r; // last sampled true leg of the first line
  // count rising edges while an event runs; a receiver only sees a pulse during it
  always_ff @(posedge hclk)
  begin
    prev_r <= sysref_out[0];
    if (clr)
    begin
      edge_count <= 8'h00;
      swing_bad <= 1'b0;
    end
    else
    begin
      // a new pulse on the line
      if (active && sysref_out[0] && !prev_r)
      begin
        edge_count <= edge_count + 8'h01;
      end
      // the receiver is terminated for the 500 mV code only
      if (active && ref_swing[0] !== 2'b01)
      begin
        swing_bad <= 1'b1;
      end
    end
  end
endmodule // conv_model
`default_nettype wire

/* File: verif/sysref_output_state_and_delay_ctrl_tb.sv */
// bench: registers, line states, event handling and delays of the output controller
`timescale 1ns/1ps
`default_nettype none
module sysref_output_state_and_delay_ctrl_tb;
  import sref_pkg::*;
  // bus and clock
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, clr;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0] htrans;
  logic [2:0] hsize;
  // activity pins
  logic sysref_event, sysref_pulse, vcxo_clk;
  logic [4:0] chan_clk;
  // outputs
  ref_vec_t sysref_out, sysref_out_complement, ref_line_bias, ref_power_on;
  logic [6:0][1:0] ref_swing;
  logic [6:0][17:0] ref_delay_ps;
  clk_vec_t clock_out, clock_power_on;
  logic [7:0][1:0] clock_swing;
  logic [4:0][15:0] clock_delay_ps;
  logic vcxo_clock_out, vcxo_out_power_on, vcxo_style, sysref_event_active;
  logic [1:0] vcxo_swing;
  logic [7:0] edge_count;
  logic swing_bad;
  logic [31:0] word;
  int n_fail = 0;
  int n_tests = 0;
  // single slave: its ready is the bus ready
  assign hready = hreadyout;

  sysref_output_ctrl sysref_output_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sysref_event(sysref_event), .sysref_pulse(sysref_pulse), .chan_clk(chan_clk),
    .vcxo_clk(vcxo_clk), .sysref_out(sysref_out), .sysref_out_complement(sysref_out_complement),
    .ref_line_bias(ref_line_bias), .ref_power_on(ref_power_on), .ref_swing(ref_swing),
    .ref_delay_ps(ref_delay_ps), .clock_out(clock_out), .clock_power_on(clock_power_on),
    .clock_swing(clock_swing), .clock_delay_ps(clock_delay_ps),
    .vcxo_clock_out(vcxo_clock_out), .vcxo_out_power_on(vcxo_out_power_on),
    .vcxo_swing(vcxo_swing), .vcxo_style(vcxo_style),
    .sysref_event_active(sysref_event_active));

  conv_model conv_model_i (.hclk(hclk), .clr(clr), .sysref_out(sysref_out),
    .ref_swing(ref_swing), .active(sysref_event_active), .edge_count(edge_count),
    .swing_bad(swing_bad));

  // 10 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // compare a value seen on the bus
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t read %h expected %h", $time, got, exp);
    end
  endtask

  // compare a value seen on output pins
  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t pins %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait for ready at a rising edge
  task automatic rdy();
    int i = 0;
    do
    begin
      @(posedge hclk);
      i++;
    end
    while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1)
    begin
      n_fail++;
      $display("ERROR %0t bus never ready", $time);
      end_of_test();
    end
  endtask

  // single word write: address phase, then data phase
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0000_00, a};
    htrans <= 2'b10;
    hwrite <= 1'b1;
    rdy();
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    chk_pin({31'h0, hresp}, 32'h0000_0000);
  endtask

  // single word read, data taken at the closing edge
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    hsel <= 1'b1;
    haddr <= {24'h0000_00, a};
    htrans <= 2'b10;
    hwrite <= 1'b0;
    rdy();
    htrans <= 2'b00;
    rdy();
    chk_reg(hrdata, exp);
  endtask

  // covers one write-to-output edge plus the two-stage input sync
  task automatic settle();
    repeat (4) @(posedge hclk);
  endtask

  // bounded wait for the event flag to reach a level
  task automatic wait_active(input logic v);
    int i = 0;
    while (sysref_event_active !== v && i < 20)
    begin
      @(posedge hclk);
      i++;
    end
    chk_pin(sysref_event_active, v);
    // a flag that never came ends the run
    if (sysref_event_active !== v)
    begin
      end_of_test();
    end
  endtask

  // main sequence
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    sysref_event = 1'b0;
    sysref_pulse = 1'b0;
    chan_clk = 5'b0_0000;
    vcxo_clk = 1'b0;
    clr = 1'b1;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    clr <= 1'b0;
    // reset values, writable bits, unmapped place
    for (int k = 0; k < NREG; k++) rd_chk(8'(k * 4), RST_VAL[k]);
    for (int k = 0; k < NREG; k++) wr(8'(k * 4), 32'hFFFF_FFFF);
    for (int k = 0; k < NREG; k++) rd_chk(8'(k * 4), WMASK[k]);
    wr(8'h28, 32'hFFFF_FFFF);
    rd_chk(8'h28, 32'h0000_0000);
    for (int k = 0; k < NREG; k++) wr(8'(k * 4), RST_VAL[k]);
    $display("test registers done");
    // swing per output and the oscillator-loop output
    wr(OFS_REF_SWING, 32'h0000_2D39);
    wr(OFS_CLK_SWING, 32'h0000_E41B);
    wr(OFS_ROLE, 32'h0000_3600);
    vcxo_clk <= 1'b1;
    settle();
    chk_pin(32'(ref_swing), 32'h0000_2D39);
    chk_pin(32'(clock_swing), 32'h0000_E41B);
    chk_pin({28'h0, vcxo_out_power_on, vcxo_swing, vcxo_clock_out}, 32'h0000_000F);
    chk_pin({31'h0, vcxo_style}, 32'h0000_0001);
    wr(OFS_ROLE, 32'h0000_1000);
    wr(OFS_REF_SWING, 32'h0000_1555);
    settle();
    chk_pin({31'h0, vcxo_out_power_on}, 32'h0000_0000);
    $display("test swing done");
    // idle line states: six outputs in sysref role, one in clock role, output 4 disabled
    wr(OFS_ROLE, 32'h0000_103F);
    wr(OFS_REF_CTRL, 32'h0000_006F);
    settle();
    chk_pin({25'h0, sysref_out}, 32'h0000_0000);
    chk_pin({26'h0, sysref_out_complement[5:0]}, 32'h0000_003F);
    chk_pin({26'h0, ref_line_bias[5:0]}, 32'h0000_0000);
    wr(OFS_ROLE, 32'h0000_113F);
    settle();
    chk_pin({26'h0, ref_line_bias[5:0]}, 32'h0000_002F);
    chk_pin({26'h0, sysref_out[5:0]}, 32'h0000_0000);
    chk_pin({26'h0, sysref_out_complement[5:0]}, 32'h0000_0010);
    wr(OFS_ROLE, 32'h0000_103F);
    wr(OFS_REF_CTRL, 32'h0000_106F);
    settle();
    chk_pin({26'h0, ref_line_bias[5:0]}, 32'h0000_0010);
    $display("test idle done");
    // event with six pulses; clock-role output keeps following its channel
    wr(OFS_REF_CTRL, 32'h0000_007F);
    wr(OFS_CLK_CTRL, 32'h0000_00FF);
    chan_clk <= 5'b1_0101;
    settle();
    chk_pin({24'h0, clock_out}, 32'h0000_00D3);
    sysref_event <= 1'b1;
    sysref_pulse <= 1'b1;
    wait_active(1'b1);
    repeat (3) @(posedge hclk);
    chk_pin({25'h0, sysref_out}, 32'h0000_003F);
    chk_pin({26'h0, sysref_out_complement[5:0]}, 32'h0000_0000);
    rd_chk(OFS_STATUS, 32'h00FF_7F01);
    repeat (5)
    begin
      sysref_pulse <= 1'b0;
      repeat (4) @(posedge hclk);
      sysref_pulse <= 1'b1;
      repeat (4) @(posedge hclk);
    end
    sysref_pulse <= 1'b0;
    repeat (4) @(posedge hclk);
    sysref_event <= 1'b0;
    wait_active(1'b0);
    settle();
    chk_pin({25'h0, sysref_out}, 32'h0000_0000);
    chk_pin({26'h0, sysref_out_complement[5:0]}, 32'h0000_003F);
    chk_pin({24'h0, edge_count}, 32'h0000_0006);
    chk_pin({31'h0, swing_bad}, 32'h0000_0000);
    $display("test event done");
    // channel A and clock output 7 powered down
    wr(OFS_CLK_CTRL, 32'h0100_80FF);
    settle();
    chk_pin({24'h0, clock_power_on}, 32'h0000_007C);
    chk_pin({24'h0, clock_out}, 32'h0000_0050);
    chk_pin({29'h0, ref_power_on[2:0]}, 32'h0000_0000);
    chk_pin({29'h0, sysref_out[2:0] | sysref_out_complement[2:0]}, 32'h0000_0000);
    wr(OFS_CLK_CTRL, 32'h0000_00FF);
    $display("test power down done");
    // clock delays at boundary steps, sysref delays over all codes
    wr(OFS_CLK_DLY_AD, 32'hFF80_0100);
    wr(OFS_DLY_E_GLB, 32'h0000_FF02);
    settle();
    chk_pin(32'(clock_delay_ps[0]), 32'd0);
    chk_pin(32'(clock_delay_ps[1]), 32'd254);
    chk_pin(32'(clock_delay_ps[2]), 32'd32512);
    chk_pin(32'(clock_delay_ps[3]), 32'd64770);
    chk_pin(32'(clock_delay_ps[4]), 32'd508);
    for (int k = 0; k < 8; k++)
    begin
      word = '0;
      for (int i = 0; i < NREF; i++) word = word | (32'(k) << (3 * i));
      wr(OFS_REF_COARSE, word);
      wr(OFS_REF_FINE, word);
      settle();
      for (int i = 0; i < 6; i++)
        chk_pin(32'(ref_delay_ps[i]), 32'(255 * 509 + k * 127 + FINE_PS[k]));
      chk_pin(32'(ref_delay_ps[6]), 32'd64770);
    end
    // output 6 in sysref role: fine code alone on output 0, coarse alone then coarse plus global on output 6
    wr(OFS_ROLE, 32'h0000_107F);
    wr(OFS_DLY_E_GLB, 32'h0000_0002);
    wr(OFS_REF_COARSE, 32'h0004_0000);
    wr(OFS_REF_FINE, 32'h0000_0004);
    settle();
    chk_pin(32'(ref_delay_ps[0]), 32'h0000_0055);
    chk_pin(32'(ref_delay_ps[6]), 32'(COARSE_STEP_PS));
    wr(OFS_DLY_E_GLB, 32'h0000_2902);
    settle();
    chk_pin(32'(ref_delay_ps[6]), 32'(41 * GLOBAL_STEP_PS + COARSE_STEP_PS));
    $display("test delay done");
    end_of_test();
  end
endmodule // sysref_output_state_and_delay_ctrl_tb
`default_nettype wire
